// ==== common/cmd_interp_map.svh ====
`ifndef CMD_INTERP_MAP_SVH
`define CMD_INTERP_MAP_SVH

// Command codes, bits 5..0 of the first command word
`define OP_HI 5
`define OP_ABORT 6'h0f
`define OP_ASSIGN 6'h0e
`define OP_INQUIRY 6'h0b
`define OP_FORMAT_UNIT 6'h16

// Device numbers
`define SUBSYS_DEV 4'hf
`define NUM_LDN 15

// First word option bits
`define W0_NO_DISCONNECT 7
`define W0_NO_SYNC_NEG 6

// Second word (enable options) bits
`define W1_STATUS_ON_ERROR_ONLY 14
`define W1_RETRY_OPTION 13
`define W1_SUPPRESS_SHORT 10
`define W1_CHAIN_ON_SUCCESS 0

// Second word of the assign request
`define ASG_REMOVE_BIT 7
`define ASG_PUN_HI 10
`define ASG_PUN_LO 8
`define ASG_LDN_HI 3
`define ASG_LDN_LO 0

// Interrupt identifiers
`define IRQ_ID_OK 4'h1
`define IRQ_ID_IMMEDIATE_OK 4'ha
`define IRQ_ID_FAIL 4'hc
`define IRQ_ID_SEQ_ERR 4'hf

// Reset values
`define OWN_ID_DEFAULT 3'h7
`define PROGRESS_RESET 4'h0

`endif

// ==== common/cmd_interp_pkg.sv ====
package cmd_interp_pkg;
   typedef logic [3:0] dev_t;
   typedef logic [3:0] irq_id_t;
   typedef logic [2:0] pun_t;
   typedef logic [5:0] opcode_t;

   typedef enum logic [2:0] {
      EV_PHASE = 3'h0,
      EV_DONE = 3'h1,
      EV_XFER_DONE = 3'h2,
      EV_SEL_TIMEOUT = 3'h3,
      EV_ERROR = 3'h4,
      EV_ABORT_DONE = 3'h5
   } ev_kind_e;

   typedef struct packed {
      dev_t dev;
      logic isBlock;
      logic [15:0] word1;
      logic [15:0] word0;
   } cmd_s;

   typedef struct packed {
      logic valid;
      dev_t dev;
      pun_t physical_target_number;
      opcode_t opcode;
      logic retryEn;
      logic noDisconnect;
      logic noSyncNeg;
      logic statusOnErrorOnly;
      logic suppressShort;
      logic chainOnSuccess;
   } start_s;

   typedef struct packed {
      logic valid;
      dev_t dev;
      pun_t physical_target_number;
   } abort_s;

   typedef struct packed {
      logic valid;
      ev_kind_e kind;
      dev_t dev;
      logic [3:0] phase;
   } target_ev_s;

   typedef struct packed {
      logic running;
      opcode_t opcode;
      irq_id_t irqId;
      logic [3:0] progress;
      logic aborted;
      logic selTimeout;
   } status_s;

   typedef struct packed {
      dev_t dev;
      irq_id_t id;
   } int_stat_s;

   typedef struct packed {
      logic valid;
      dev_t ldn;
      pun_t physical_target_number;
      logic remove;
   } bind_req_s;

   typedef struct packed {
      logic valid;
      irq_id_t id;
   } bind_resp_s;

   typedef struct packed {
      logic bound;
      logic retryEn;
      pun_t physical_target_number;
   } bind_entry_s;
endpackage

// ==== rtl/device_binding_table.sv ====
`timescale 1ns/1ps
`include "cmd_interp_map.svh"

module device_binding_table
   import cmd_interp_pkg::*;
#(
   parameter int NUM_LDN = `NUM_LDN,
   parameter int DEFAULT_BOUND = 7
) (
   input wire logic clk,
   input wire logic rstSync_n,
   input wire pun_t ownScsiId,
   input wire bind_req_s bindReq,
   output bind_resp_s bindResp,
   output bind_entry_s [NUM_LDN-1:0] entries
);
   typedef struct packed {
      bind_entry_s [NUM_LDN-1:0] table_;
      bind_resp_s resp;
   } state_s;

   state_s s;
   state_s next_s;

   function automatic state_s resetState();
      state_s r;
      r.resp = '0;
      for (int i = 0; i < NUM_LDN; i++) begin
         r.table_[i].bound = (i < DEFAULT_BOUND);
         r.table_[i].retryEn = (i < DEFAULT_BOUND);
         r.table_[i].physical_target_number = pun_t'(i);
      end
      return r;
   endfunction

   always_comb begin
      logic taken;
      taken = 1'b0;
      next_s = s;
      next_s.resp = '0;
      if (bindReq.valid) begin
         next_s.resp.valid = 1'b1;
         next_s.resp.id = `IRQ_ID_IMMEDIATE_OK;
         for (int i = 0; i < NUM_LDN; i++) begin
            if (s.table_[i].bound && s.table_[i].physical_target_number == bindReq.physical_target_number &&
                dev_t'(i) != bindReq.ldn) begin
               taken = 1'b1;
            end
         end
         if (bindReq.ldn >= dev_t'(NUM_LDN)) begin
            next_s.resp.id = `IRQ_ID_FAIL;
         // [RQ13] Remove binding
         end else if (bindReq.remove) begin
            next_s.table_[bindReq.ldn].bound = 1'b0;
            next_s.table_[bindReq.ldn].retryEn = 1'b0;
         // [RQ11] Own identifier refused
         end else if (bindReq.physical_target_number == ownScsiId) begin
            next_s.resp.id = `IRQ_ID_FAIL;
         // [RQ15] Target already bound
         end else if (taken) begin
            next_s.resp.id = `IRQ_ID_FAIL;
         end else begin
            // [RQ9] Bind ldn to target
            next_s.table_[bindReq.ldn].bound = 1'b1;
            next_s.table_[bindReq.ldn].physical_target_number = bindReq.physical_target_number;
            // [RQ10] Retries enabled
            next_s.table_[bindReq.ldn].retryEn = 1'b1;
         end
      end
   end

   // [RQ12] Reset restores defaults
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         s <= resetState();
      end else begin
         s <= next_s;
      end
   end

   assign bindResp = s.resp;
   assign entries = s.table_;
endmodule

// ==== rtl/scsi_command_interpreter.sv ====
`timescale 1ns/1ps
`include "cmd_interp_map.svh"

// Overview of operation
// [RQ1] Command code sits in bits 5..0 of the first command word.
// [RQ2] Host sends the assign request only to device 15.
// [RQ3] One status record per device, updated when its command finishes.
// [RQ4] Abort of a logical device ends it, sends identify and abort, frees bus.
// [RQ5] Abort addressed to device 15 cancels the active global command.
// [RQ6] Aborted record is kept, showing progress when stopped.
// [RQ7] Host aborts only after its own timeout expired.
// [RQ8] Interrupt raised once abort processing is finished.
// [RQ9] Assign binds logical device 0..14 to one chosen target.
// [RQ10] Binding a logical device enables its retries.
// [RQ11] Binding to the subsystem's own target number is refused.
// [RQ12] Hardware reset restores default bindings.
// [RQ13] Second word bit 7 set removes the binding instead.
// [RQ14] Rebinding a running device ends it with error, binding kept.
// [RQ15] Second binding to an already bound target fails with id C.
// [RQ16] Inquiry completion interrupt only after data transfer ends.
// [RQ17] Host asks 255 bytes with short suppression if length unknown.
// [RQ18] No target answering gives failure and a selection timeout record.
// [RQ19] Inquiry data layout: type, removable flag, compliance, length N-4.
// [RQ20] Abort word is 040F hex with a zero second word.
// [RQ21] No new interrupt or status change until end-of-interrupt.
// [RQ22] Command to a busy device ends the running one, new one dropped.

module scsi_command_interpreter
   import cmd_interp_pkg::*;
#(
   parameter int NUM_LDN = `NUM_LDN,
   parameter int DEFAULT_BOUND = 7
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire pun_t ownScsiId,
   input wire logic cmdValid,
   input wire cmd_s cmd,
   output logic cmdReady,
   input wire logic eoiValid,
   input wire dev_t eoiDev,
   output logic irq,
   output int_stat_s intStatus,
   input wire dev_t statusDev,
   output status_s statusRecord,
   output start_s tgtStart,
   output abort_s tgtAbort,
   input wire target_ev_s tgtEvent
);
   typedef struct packed {
      status_s [15:0] recs;
      logic [15:0] pending;
      irq_id_t [15:0] pendId;
      logic waiting;
      int_stat_s intStat;
      start_s start;
      abort_s abort;
      bind_req_s bindReq;
      status_s statusOut;
   } state_s;

   state_s s;
   state_s next_s;
   logic [1:0] rstSync;
   logic rstSync_n;
   bind_resp_s bindResp;
   bind_entry_s [NUM_LDN-1:0] entries;

   function automatic logic isLogical(input dev_t d);
      return d != `SUBSYS_DEV;
   endfunction

   function automatic status_s endRecord(input status_s r, input irq_id_t id);
      status_s o;
      o = r;
      o.running = 1'b0;
      o.irqId = id;
      return o;
   endfunction

   // Reset is released through two flops so all state leaves reset together
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstSync_n = rstSync[1];

   device_binding_table #(
      .NUM_LDN(NUM_LDN),
      .DEFAULT_BOUND(DEFAULT_BOUND)
   ) bindTable (
      .clk(clk),
      .rstSync_n(rstSync_n),
      .ownScsiId(ownScsiId),
      .bindReq(s.bindReq),
      .bindResp(bindResp),
      .entries(entries)
   );

   always_comb begin
      logic found;
      dev_t d;
      dev_t ldn;
      opcode_t op;
      found = 1'b0;
      d = '0;
      ldn = '0;
      op = '0;
      next_s = s;
      next_s.start.valid = 1'b0;
      next_s.abort.valid = 1'b0;
      next_s.bindReq.valid = 1'b0;
      next_s.statusOut = s.recs[statusDev];

      // [RQ21] Hold interrupt status until end-of-interrupt
      if (s.waiting) begin
         if (eoiValid && eoiDev == s.intStat.dev) begin
            next_s.waiting = 1'b0;
         end
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (!found && s.pending[i]) begin
               found = 1'b1;
               next_s.intStat.dev = dev_t'(i);
               next_s.intStat.id = s.pendId[i];
               next_s.pending[i] = 1'b0;
               next_s.waiting = 1'b1;
            end
         end
      end

      // Posts below come after the dispatch clear, so the clear never drops an event posted in the same cycle
      if (tgtEvent.valid) begin
         d = tgtEvent.dev;
         unique case (tgtEvent.kind)
            EV_PHASE: begin
               // [RQ6] Progress tracked for abort record
               if (s.recs[d].running) begin
                  next_s.recs[d].progress = tgtEvent.phase;
               end
            end
            EV_DONE: begin
               // [RQ16] Inquiry waits for transfer end
               if (s.recs[d].running && s.recs[d].opcode != `OP_INQUIRY) begin
                  // [RQ3] Record updated on finish
                  next_s.recs[d] = endRecord(s.recs[d], `IRQ_ID_OK);
                  next_s.pending[d] = 1'b1;
                  next_s.pendId[d] = `IRQ_ID_OK;
               end
            end
            EV_XFER_DONE: begin
               if (s.recs[d].running) begin
                  next_s.recs[d] = endRecord(s.recs[d], `IRQ_ID_OK);
                  next_s.pending[d] = 1'b1;
                  next_s.pendId[d] = `IRQ_ID_OK;
               end
            end
            EV_SEL_TIMEOUT: begin
               // [RQ18] Selection timeout fails command
               if (s.recs[d].running) begin
                  next_s.recs[d] = endRecord(s.recs[d], `IRQ_ID_FAIL);
                  next_s.recs[d].selTimeout = 1'b1;
                  next_s.pending[d] = 1'b1;
                  next_s.pendId[d] = `IRQ_ID_FAIL;
               end
            end
            EV_ERROR: begin
               if (s.recs[d].running) begin
                  next_s.recs[d] = endRecord(s.recs[d], `IRQ_ID_FAIL);
                  next_s.pending[d] = 1'b1;
                  next_s.pendId[d] = `IRQ_ID_FAIL;
               end
            end
            EV_ABORT_DONE: begin
               // [RQ8] Abort finished, interrupt
               next_s.pending[d] = 1'b1;
               next_s.pendId[d] = `IRQ_ID_IMMEDIATE_OK;
            end
            default: begin
            end
         endcase
      end

      if (bindResp.valid) begin
         next_s.recs[`SUBSYS_DEV] = endRecord(s.recs[`SUBSYS_DEV], bindResp.id);
         next_s.pending[`SUBSYS_DEV] = 1'b1;
         next_s.pendId[`SUBSYS_DEV] = bindResp.id;
      end

      if (cmdValid) begin
         d = cmd.dev;
         // [RQ1] Code from word 0 bits 5..0
         op = cmd.word0[`OP_HI:0];
         ldn = cmd.word1[`ASG_LDN_HI:`ASG_LDN_LO];
         // [RQ20] Abort word decoded
         if (!cmd.isBlock && op == `OP_ABORT) begin
            // [RQ6] Record kept, marked aborted
            if (s.recs[d].running) begin
               next_s.recs[d].running = 1'b0;
               next_s.recs[d].aborted = 1'b1;
               next_s.recs[d].irqId = `IRQ_ID_FAIL;
            end
            if (isLogical(d)) begin
               // [RQ4] Identify then abort to target
               next_s.abort.valid = 1'b1;
               next_s.abort.dev = d;
               next_s.abort.physical_target_number = entries[d].physical_target_number;
            end else begin
               // [RQ5] Cancel active global command
               next_s.abort.valid = s.recs[d].running;
               next_s.abort.dev = d;
               next_s.abort.physical_target_number = ownScsiId;
               // [RQ8] Global abort completes at once
               next_s.pending[d] = 1'b1;
               next_s.pendId[d] = `IRQ_ID_IMMEDIATE_OK;
            end
         // [RQ22] Busy device: sequence error
         end else if (s.recs[d].running) begin
            next_s.recs[d] = endRecord(s.recs[d], `IRQ_ID_SEQ_ERR);
            next_s.pending[d] = 1'b1;
            next_s.pendId[d] = `IRQ_ID_SEQ_ERR;
            next_s.abort.valid = 1'b1;
            next_s.abort.dev = d;
            next_s.abort.physical_target_number = isLogical(d) ? entries[d].physical_target_number : ownScsiId;
         end else if (!cmd.isBlock && op == `OP_ASSIGN) begin
            // [RQ2] Assign to a logical device is failed
            if (isLogical(d)) begin
               next_s.pending[d] = 1'b1;
               next_s.pendId[d] = `IRQ_ID_FAIL;
            // [RQ14] Running target: error, binding kept
            end else if (isLogical(ldn) && s.recs[ldn].running) begin
               next_s.recs[ldn] = endRecord(s.recs[ldn], `IRQ_ID_FAIL);
               next_s.pending[ldn] = 1'b1;
               next_s.pendId[ldn] = `IRQ_ID_FAIL;
               next_s.abort.valid = 1'b1;
               next_s.abort.dev = ldn;
               next_s.abort.physical_target_number = entries[ldn].physical_target_number;
               next_s.recs[d].irqId = `IRQ_ID_FAIL;
               next_s.recs[d].opcode = op;
               next_s.pending[d] = 1'b1;
               next_s.pendId[d] = `IRQ_ID_FAIL;
            end else begin
               next_s.recs[d].running = 1'b1;
               next_s.recs[d].opcode = op;
               next_s.recs[d].progress = `PROGRESS_RESET;
               next_s.recs[d].aborted = 1'b0;
               next_s.recs[d].selTimeout = 1'b0;
               next_s.bindReq.valid = 1'b1;
               next_s.bindReq.ldn = ldn;
               next_s.bindReq.physical_target_number = cmd.word1[`ASG_PUN_HI:`ASG_PUN_LO];
               next_s.bindReq.remove = cmd.word1[`ASG_REMOVE_BIT];
            end
         end else if (isLogical(d) && !entries[d].bound) begin
            // An unbound device has no target to talk to
            next_s.recs[d].opcode = op;
            next_s.recs[d].irqId = `IRQ_ID_FAIL;
            next_s.pending[d] = 1'b1;
            next_s.pendId[d] = `IRQ_ID_FAIL;
         end else begin
            next_s.recs[d].running = 1'b1;
            next_s.recs[d].opcode = op;
            next_s.recs[d].progress = `PROGRESS_RESET;
            next_s.recs[d].aborted = 1'b0;
            next_s.recs[d].selTimeout = 1'b0;
            next_s.start.valid = 1'b1;
            next_s.start.dev = d;
            next_s.start.physical_target_number = isLogical(d) ? entries[d].physical_target_number : ownScsiId;
            next_s.start.opcode = op;
            // [RQ10] Retry from binding
            next_s.start.retryEn = isLogical(d) ? entries[d].retryEn : 1'b0;
            next_s.start.noDisconnect = cmd.word0[`W0_NO_DISCONNECT];
            next_s.start.noSyncNeg = cmd.word0[`W0_NO_SYNC_NEG];
            next_s.start.statusOnErrorOnly = cmd.word1[`W1_STATUS_ON_ERROR_ONLY];
            next_s.start.suppressShort = cmd.word1[`W1_SUPPRESS_SHORT];
            next_s.start.chainOnSuccess = cmd.word1[`W1_CHAIN_ON_SUCCESS];
         end
      end
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Every command is taken; a non-abort command to a busy device ends the running one as a sequence error and is dropped
   assign cmdReady = 1'b1;
   assign irq = s.waiting;
   assign intStatus = s.intStat;
   assign statusRecord = s.statusOut;
   assign tgtStart = s.start;
   assign tgtAbort = s.abort;
endmodule

// ==== tb/scsi_command_interpreter_checker.sv ====
`timescale 1ns/1ps
module scsi_command_interpreter_checker
   import cmd_interp_pkg::*;
#(
   parameter int NUM_LDN = 15,
   parameter int DEFAULT_BOUND = 7
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cmdValid,
   input wire cmd_s cmd,
   input wire logic eoiValid,
   input wire dev_t eoiDev,
   input wire logic irq,
   input wire int_stat_s intStatus,
   input wire start_s tgtStart,
   input wire abort_s tgtAbort
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_start_cause: assert property (
      tgtStart.valid |-> $past(cmdValid) && tgtStart.dev == $past(cmd.dev))
      else $error("start pulse without a command");
   a_start_opcode: assert property (
      tgtStart.valid |-> tgtStart.opcode == $past(cmd.word0[5:0]))
      else $error("start opcode differs from command bits 5..0");
   a_start_pulse: assert property (
      tgtStart.valid && !cmdValid |=> !tgtStart.valid)
      else $error("start pulse longer than one cycle");
   a_start_retry: assert property (
      tgtStart.valid && tgtStart.dev != 4'hf |-> tgtStart.retryEn)
      else $error("bound device started without retries");
   a_abort_cause: assert property (
      tgtAbort.valid |-> $past(cmdValid))
      else $error("abort pulse without a command");
   a_abort_dev: assert property (
      tgtAbort.valid && $past(cmdValid && cmd.word0 == 16'h040f)
      |-> tgtAbort.dev == $past(cmd.dev))
      else $error("abort pulse names the wrong device");
   a_irq_held: assert property (
      irq && !(eoiValid && eoiDev == intStatus.dev) |=> irq && $stable(intStatus))
      else $error("interrupt status changed before end of interrupt");
   a_eoi_clears: assert property (
      irq && eoiValid && eoiDev == intStatus.dev |=> !irq)
      else $error("interrupt not withdrawn after end of interrupt");
   a_irq_id_known: assert property (
      $rose(irq) |-> intStatus.id inside {4'h1, 4'ha, 4'hc, 4'hf})
      else $error("interrupt posted with unknown identifier");
endmodule

bind scsi_command_interpreter scsi_command_interpreter_checker #(
   .NUM_LDN(NUM_LDN), .DEFAULT_BOUND(DEFAULT_BOUND)
) scsi_command_interpreter_checker_i (
   .clk(clk), .reset_n(reset_n), .cmdValid(cmdValid), .cmd(cmd), .eoiValid(eoiValid),
   .eoiDev(eoiDev), .irq(irq), .intStatus(intStatus), .tgtStart(tgtStart), .tgtAbort(tgtAbort)
);

// ==== tb/target_engine_model.sv ====
`timescale 1ns/1ps
module target_engine_model
   import cmd_interp_pkg::*;
(
   input wire logic clk,
   input wire start_s tgtStart,
   input wire abort_s tgtAbort,
   input wire logic [4:0] lag,
   input wire pun_t absentPun,
   output target_ev_s tgtEvent
);
   start_s jobs[$];
   dev_t cuts[$];
   logic [15:0] dropped = '0;
   start_s cur;
   initial tgtEvent = '0;
   always @(posedge clk) begin
      if (tgtStart.valid) begin
         dropped[tgtStart.dev] = 1'b0;
         jobs.push_back(tgtStart);
      end
      if (tgtAbort.valid) begin
         dropped[tgtAbort.dev] = 1'b1;
         cuts.push_back(tgtAbort.dev);
      end
   end
   task automatic emit(input ev_kind_e k, input dev_t d);
      tgtEvent <= '{1'b1, k, d, 4'h3};
      @(posedge clk);
      // Released fields show the inverse, so a stale copy is never read as valid
      tgtEvent <= '{1'b0, ev_kind_e'(~k), ~d, 4'hc};
   endtask
   // Targets are served one at a time, as a single shared bus would
   always begin
      @(posedge clk);
      if (cuts.size() > 0) begin
         repeat (3) @(posedge clk);
         emit(EV_ABORT_DONE, cuts.pop_front());
      end else if (jobs.size() > 0) begin
         cur = jobs.pop_front();
         emit(EV_PHASE, cur.dev);
         repeat (lag) @(posedge clk);
         if (dropped[cur.dev]) cur.valid = 1'b0;
         // nobody answers at the absent target
         else if (cur.physical_target_number == absentPun) emit(EV_SEL_TIMEOUT, cur.dev);
         // data block moved before the transfer ends
         else if (cur.opcode == 6'h0b) emit(EV_XFER_DONE, cur.dev);
         else emit(EV_DONE, cur.dev);
      end
   end
endmodule

// ==== tb/tb_scsi_subsystem_command_interpreter.sv ====
`timescale 1ns/1ps
module tb_scsi_subsystem_command_interpreter
   import cmd_interp_pkg::*;
();
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cmdValid = 1'b0;
   logic eoiValid = 1'b0;
   cmd_s cmd = '0;
   dev_t eoiDev = '0;
   dev_t statusDev = '0;
   logic [4:0] lag = 5'h02;
   logic cmdReady;
   logic irq;
   int_stat_s intStatus;
   status_s statusRecord;
   start_s tgtStart;
   abort_s tgtAbort;
   target_ev_s tgtEvent;
   start_s startQ[$];
   int_stat_s irqQ[$];
   dev_t abortQ[$];
   opcode_t ops[4] = '{6'h01, 6'h02, 6'h03, 6'h09};
   int err_total = 0;
   int compares = 0;

   always #20 clk = ~clk;

   scsi_command_interpreter scsi_command_interpreter_i (
      .clk(clk), .reset_n(reset_n), .ownScsiId(3'h7), .cmdValid(cmdValid), .cmd(cmd),
      .cmdReady(cmdReady), .eoiValid(eoiValid), .eoiDev(eoiDev), .irq(irq),
      .intStatus(intStatus), .statusDev(statusDev), .statusRecord(statusRecord),
      .tgtStart(tgtStart), .tgtAbort(tgtAbort), .tgtEvent(tgtEvent)
   );
   target_engine_model target_engine_model_i (
      .clk(clk), .tgtStart(tgtStart), .tgtAbort(tgtAbort), .lag(lag),
      .absentPun(3'h5), .tgtEvent(tgtEvent)
   );

   task automatic check(input logic ok, input string what);
      compares++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   task automatic chk_start;
      check(startQ.size() > 0 && tgtStart === startQ.pop_front(), "start request");
   endtask
   task automatic chk_abort;
      check(abortQ.size() > 0 && tgtAbort.dev === abortQ.pop_front(), "abort request");
   endtask
   task automatic chk_irq;
      check(irqQ.size() > 0 && intStatus === irqQ.pop_front(), "interrupt status");
   endtask
   task automatic chk_rec(input dev_t d, input status_s e);
      @(posedge clk);
      statusDev <= d;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(statusRecord === e, "status record");
   endtask
   task automatic tally_and_finish;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic send(input dev_t d, input logic blk, input logic [15:0] w0,
                       input logic [15:0] w1);
      @(posedge clk);
      cmdValid <= 1'b1;
      cmd <= '{d, blk, w1, w0};
      @(posedge clk);
      cmdValid <= 1'b0;
      cmd <= ~cmd;
   endtask
   task automatic settle;
      int n = 0;
      while (irqQ.size() + startQ.size() + abortQ.size() > 0 || irq !== 1'b0) begin
         @(posedge clk);
         n++;
         if (n > 3000) begin
            check(1'b0, "queue never drained");
            return;
         end
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic cmdx(input dev_t d, input logic blk, input logic [15:0] w0,
                       input logic [15:0] w1, input irq_id_t id);
      irqQ.push_back('{d, id});
      send(d, blk, w0, w1);
      settle();
   endtask
   task automatic assign_req(input dev_t ldn, input pun_t p, input logic rm, input irq_id_t id);
      cmdx(4'hf, 1'b0, 16'h040e, {5'h00, p, rm, 3'h0, ldn}, id);
   endtask
   task automatic job(input dev_t d, input pun_t p, input opcode_t op, input irq_id_t id);
      logic [15:0] w0;
      logic [15:0] w1;
      w0 = {8'h00, 2'($urandom), op};
      w1 = 16'($urandom) & 16'h4401;
      if (op == 6'h0b) w1 = w1 | 16'h0400;
      startQ.push_back('{1'b1, d, p, op, 1'b1, w0[7], w0[6], w1[14], w1[10], w1[0]});
      if (id != 4'h0) irqQ.push_back('{d, id});
      send(d, 1'b1, w0, w1);
   endtask

   initial begin
      forever begin
         @(negedge clk);
         if (tgtStart.valid === 1'b1) chk_start();
         if (tgtAbort.valid === 1'b1) chk_abort();
         if (cmdValid === 1'b1) check(cmdReady === 1'b1, "command not taken");
      end
   end
   // Host side: answers each interrupt, first with a wrong device number
   initial begin
      dev_t d;
      forever begin
         @(negedge clk);
         if (irq === 1'b1) begin
            d = intStatus.dev;
            chk_irq();
            @(posedge clk);
            eoiValid <= 1'b1;
            eoiDev <= d ^ 4'h1;
            @(posedge clk);
            eoiDev <= d;
            @(posedge clk);
            eoiValid <= 1'b0;
            eoiDev <= ~d;
            @(negedge clk);
            check(irq === 1'b0, "interrupt kept after end of interrupt");
         end
      end
   end
   // Far beyond the few hundred cycles the sequence needs
   initial begin
      #2000000;
      check(1'b0, "watchdog expired");
      tally_and_finish();
   end

   initial begin
      dev_t d;
      void'($urandom(95));
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         // Target 5 is the absent one, so keep clear of device 5
         d = dev_t'($urandom_range(0, 4));
         job(d, pun_t'(d), ops[i], 4'h1);
         settle();
      end
      chk_rec(d, '{1'b0, ops[3], 4'h1, 4'h3, 1'b0, 1'b0});
      job(4'h3, 3'h3, 6'h0b, 4'h1);
      settle();
      assign_req(4'h5, 3'h5, 1'b1, 4'ha);
      assign_req(4'h8, 3'h5, 1'b0, 4'ha);
      assign_req(4'h9, 3'h5, 1'b0, 4'hc);
      assign_req(4'h9, 3'h7, 1'b0, 4'hc);
      cmdx(4'h5, 1'b1, 16'h0001, 16'h0000, 4'hc);
      job(4'h8, 3'h5, 6'h0b, 4'hc);
      settle();
      chk_rec(4'h8, '{1'b0, 6'h0b, 4'hc, 4'h3, 1'b0, 1'b1});
      lag <= 5'h14;
      job(4'h1, 3'h1, 6'h01, 4'h0);
      // abort only after the host has waited
      repeat (6) @(posedge clk);
      abortQ.push_back(4'h1);
      cmdx(4'h1, 1'b0, 16'h040f, 16'h0000, 4'ha);
      chk_rec(4'h1, '{1'b0, 6'h01, 4'hc, 4'h3, 1'b1, 1'b0});
      // Removal of busy device 2 must fail and leave its binding
      job(4'h2, 3'h2, 6'h01, 4'h0);
      abortQ.push_back(4'h2);
      irqQ.push_back('{4'h2, 4'hc});
      irqQ.push_back('{4'hf, 4'hc});
      irqQ.push_back('{4'h2, 4'ha});
      send(4'hf, 1'b0, 16'h040e, {5'h00, 3'h0, 1'b1, 3'h0, 4'h2});
      settle();
      job(4'h2, 3'h2, 6'h01, 4'h1);
      settle();
      job(4'h4, 3'h4, 6'h02, 4'h0);
      abortQ.push_back(4'h4);
      irqQ.push_back('{4'h4, 4'hf});
      cmdx(4'h4, 1'b1, 16'h0002, 16'h0000, 4'ha);
      cmdx(4'hf, 1'b0, 16'h040f, 16'h0000, 4'ha);
      // Mid-run reset must drop the binding of device 8 again
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      cmdx(4'h8, 1'b1, 16'h0001, 16'h0000, 4'hc);
      tally_and_finish();
   end
endmodule
